// *** ptl_pkg.sv ***
package ptl_pkg;

  // register indices; the byte address on the bus is four times the index
  localparam logic [6:0] IDX_LEVEL_FOUR_TOP = 7'h76;
  localparam logic [6:0] IDX_PACK_FOUR_FIVE = 7'h77;
  localparam logic [6:0] IDX_PACK_FIVE_SEVEN = 7'h78;
  localparam logic [6:0] IDX_PACK_SEVEN_EIGHT = 7'h79;
  localparam logic [6:0] IDX_LEVEL_NINTH = 7'h7a;
  localparam logic [6:0] IDX_LEVEL_TENTH = 7'h7b;
  localparam logic [6:0] IDX_LEVEL_ELEVENTH = 7'h7c;
  localparam logic [6:0] IDX_LEVEL_TWELFTH = 7'h7d;
  localparam logic [6:0] IDX_LEVEL_OFFSET = 7'h7e;
  localparam logic [6:0] IDX_CHECKSUM = 7'h7f;

  // storage slots, slot 0 sits at IDX_LEVEL_FOUR_TOP
  localparam int unsigned MAP_BYTES = 9;
  localparam logic [3:0] MAP_LAST = 4'h8;
  // writable bits per slot; the rest read as zero and ignore writes
  localparam logic [8:0][7:0] MAP_MASK = {8'h0f, 8'hff, 8'hff, 8'hff, 8'hff,
                                          8'hff, 8'hff, 8'hff, 8'h01};

  // field positions inside the packed slots
  localparam int unsigned L4_TOP_BIT = 0;
  localparam int unsigned L5_LOW_BIT = 7;
  localparam int unsigned L6_MSB = 6;
  localparam int unsigned L6_LSB = 2;
  localparam int unsigned L8_MSB = 4;
  localparam int unsigned OFFSET_MSB = 3;

  // checksum engine
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'hff;
  // commit edge to done pulse, in cycles
  localparam int unsigned CRC_LATENCY = 10;

  typedef enum logic [0:0] {
    PTL_CRC_IDLE = 1'b0,
    PTL_CRC_RUN = 1'b1
  } ptl_crc_state_t;

endpackage

// *** ptl_crc_engine.sv ***
`timescale 1ns/1ps
module ptl_crc_engine (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [7:0] byte_i,
  output logic [3:0] byte_sel_o,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] crc_o
);

  ptl_pkg::ptl_crc_state_t state;
  ptl_pkg::ptl_crc_state_t next_state;
  logic [3:0] cnt;
  logic [7:0] acc;
  logic last_byte;

  // msb-first crc-8 over one byte
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ ptl_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  assign last_byte = (cnt == ptl_pkg::MAP_LAST);
  assign byte_sel_o = cnt;
  assign busy_o = (state == ptl_pkg::PTL_CRC_RUN);

  always_comb begin
    case (state)
      ptl_pkg::PTL_CRC_IDLE: next_state = start_i ? ptl_pkg::PTL_CRC_RUN : ptl_pkg::PTL_CRC_IDLE;
      ptl_pkg::PTL_CRC_RUN: begin
        if (start_i) begin
          next_state = ptl_pkg::PTL_CRC_RUN;
        end else begin
          next_state = last_byte ? ptl_pkg::PTL_CRC_IDLE : ptl_pkg::PTL_CRC_RUN;
        end
      end
      default: next_state = ptl_pkg::PTL_CRC_IDLE;
    endcase
  end

  // a new start mid-walk restarts, so a byte already passed is never stale
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ptl_pkg::PTL_CRC_IDLE;
      cnt <= 4'h0;
      acc <= ptl_pkg::CRC_INIT;
      done_o <= 1'b0;
      crc_o <= 8'h00;
    end else begin
      state <= next_state;
      done_o <= busy_o && last_byte && !start_i;
      if (start_i) begin
        cnt <= 4'h0;
        acc <= ptl_pkg::CRC_INIT;
      end else if (busy_o) begin
        cnt <= cnt + 4'h1;
        acc <= crc_step(acc, byte_i);
        if (last_byte) begin
          crc_o <= crc_step(acc, byte_i);
        end
      end
    end
  end

endmodule

// *** ptl_level_bank.sv ***
// Behaviour
// - level four low nibble at 77h 7:4
// - level four top bit at 76h bit 0
// - level five bits 4:1 at 77h 3:0
// - level five bit 0 at 78h bit 7
// - level six at 78h bits 6:2
// - level seven split 78h 1:0, 79h 7:5
// - level eight at 79h bits 4:0
// - levels nine, ten fill 7Ah, 7Bh
// - levels eleven, twelve fill 7Ch, 7Dh
// - two's-complement offset at 7Eh bits 3:0
// - levels and offset undefined until written
// - checksum register at 7Fh over map
// - any map write recomputes the checksum
`timescale 1ns/1ps
module ptl_level_bank (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [8:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic [4:0] second_preset_level_four_o,
  output logic [4:0] second_preset_level_five_o,
  output logic [4:0] second_preset_level_six_o,
  output logic [4:0] second_preset_level_seven_o,
  output logic [4:0] second_preset_level_eight_o,
  output logic [7:0] second_preset_level_nine_o,
  output logic [7:0] second_preset_level_ten_o,
  output logic [7:0] second_preset_level_eleven_o,
  output logic [7:0] second_preset_level_twelve_o,
  output logic [3:0] second_preset_level_offset_o,
  output logic [7:0] threshold_map_checksum_o,
  output logic checksum_busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] map_q [ptl_pkg::MAP_BYTES];
  logic [7:0] checksum;
  logic [6:0] bus_idx;
  logic req;
  logic wr_commit;
  logic [ptl_pkg::MAP_BYTES-1:0] slot_hit;
  logic map_write;
  logic [7:0] bus_byte;
  logic [3:0] crc_sel;
  logic [7:0] crc_byte;
  logic crc_done;
  logic [7:0] crc_value;

  // masked read of one slot; reserved bits come back as zero
  function automatic logic [7:0] slot_read(input logic [3:0] s, input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    if (s <= ptl_pkg::MAP_LAST) begin
      r = v & ptl_pkg::MAP_MASK[s];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  assign bus_idx = adr_i[8:2];
  assign req = cyc_i && stb_i;
  // writes land on the edge where the master sees ack, and only on lane 0
  assign wr_commit = req && we_i && ack_o && sel_i[0];
  assign map_write = |slot_hit;

  genvar g;
  generate
    for (g = 0; g < ptl_pkg::MAP_BYTES; g++) begin : g_slot
      assign slot_hit[g] = wr_commit && (bus_idx == ptl_pkg::IDX_LEVEL_FOUR_TOP + 7'(g));
      // no reset
      // storage is left uninitialised on purpose; only a write defines it
      // mask reserved bits
      always_ff @(posedge clk_i) begin
        if (slot_hit[g]) begin
          map_q[g] <= dat_i[7:0] & ptl_pkg::MAP_MASK[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // bus readback of checksum and map slots
  assign bus_byte = (bus_idx == ptl_pkg::IDX_CHECKSUM) ? checksum :
                    (bus_idx >= ptl_pkg::IDX_LEVEL_FOUR_TOP) ?
                    slot_read(4'(bus_idx - ptl_pkg::IDX_LEVEL_FOUR_TOP),
                              map_q[4'(bus_idx - ptl_pkg::IDX_LEVEL_FOUR_TOP)]) :
                    8'h00;
  assign crc_byte = (crc_sel <= ptl_pkg::MAP_LAST) ? slot_read(crc_sel, map_q[crc_sel]) : 8'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req && !ack_o;
      if (req && !ack_o) begin
        dat_o <= {24'h00_0000, bus_byte};
      end
    end
  end

  ptl_crc_engine u_crc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(map_write),
    .byte_i(crc_byte),
    .byte_sel_o(crc_sel),
    .busy_o(checksum_busy_o),
    .done_o(crc_done),
    .crc_o(crc_value)
  );

  // hardware-only update
  // bus writes to the checksum are dropped; it has no value before the first walk
  always_ff @(posedge clk_i) begin
    if (crc_done) begin
      checksum <= crc_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // level four join
  assign second_preset_level_four_o = {map_q[0][ptl_pkg::L4_TOP_BIT], map_q[1][7:4]};
  assign second_preset_level_five_o = {map_q[1][3:0], map_q[2][ptl_pkg::L5_LOW_BIT]};
  assign second_preset_level_six_o = map_q[2][ptl_pkg::L6_MSB:ptl_pkg::L6_LSB];
  assign second_preset_level_seven_o = {map_q[2][1:0], map_q[3][7:5]};
  assign second_preset_level_eight_o = map_q[3][ptl_pkg::L8_MSB:0];
  assign second_preset_level_nine_o = map_q[4];
  assign second_preset_level_ten_o = map_q[5];
  assign second_preset_level_eleven_o = map_q[6];
  assign second_preset_level_twelve_o = map_q[7];
  assign second_preset_level_offset_o = map_q[8][ptl_pkg::OFFSET_MSB:0];
  assign threshold_map_checksum_o = checksum;

  ////////////////////////////////////////////////////////////////////////////
  // assertion helper: the checksum holds no value until a first walk ends
  logic checksum_seen;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      checksum_seen <= 1'b0;
    end else if (crc_done) begin
      checksum_seen <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  function automatic logic wr_to(input logic [6:0] idx);
    return wr_commit && (bus_idx == idx);
  endfunction

  a_ack_single_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_after_req: assert property (req && !ack_o |=> ack_o)
    else $error("ack missing one cycle after request");
  a_level_four_low: assert property (
    wr_to(ptl_pkg::IDX_PACK_FOUR_FIVE) |=> second_preset_level_four_o[3:0] == $past(dat_i[7:4]))
    else $error("level four low nibble wrong");
  a_level_four_top: assert property (
    wr_to(ptl_pkg::IDX_LEVEL_FOUR_TOP) |=> second_preset_level_four_o[4] == $past(dat_i[0]))
    else $error("level four top bit wrong");
  a_level_five_high: assert property (
    wr_to(ptl_pkg::IDX_PACK_FOUR_FIVE) |=> second_preset_level_five_o[4:1] == $past(dat_i[3:0]))
    else $error("level five high bits wrong");
  a_level_five_low: assert property (
    wr_to(ptl_pkg::IDX_PACK_FIVE_SEVEN) |=> second_preset_level_five_o[0] == $past(dat_i[7]))
    else $error("level five low bit wrong");
  a_level_six_field: assert property (
    wr_to(ptl_pkg::IDX_PACK_FIVE_SEVEN) |=> second_preset_level_six_o == $past(dat_i[6:2]))
    else $error("level six wrong");
  a_level_seven_split: assert property (
    wr_to(ptl_pkg::IDX_PACK_SEVEN_EIGHT) |=> second_preset_level_seven_o[2:0] == $past(dat_i[7:5]))
    else $error("level seven low bits wrong");
  a_level_seven_high: assert property (
    wr_to(ptl_pkg::IDX_PACK_FIVE_SEVEN) |=> second_preset_level_seven_o[4:3] == $past(dat_i[1:0]))
    else $error("level seven high bits wrong");
  a_level_eight_field: assert property (
    wr_to(ptl_pkg::IDX_PACK_SEVEN_EIGHT) |=> second_preset_level_eight_o == $past(dat_i[4:0]))
    else $error("level eight wrong");
  a_level_nine_byte: assert property (
    wr_to(ptl_pkg::IDX_LEVEL_NINTH) |=> second_preset_level_nine_o == $past(dat_i[7:0]))
    else $error("level nine wrong");
  a_level_ten_byte: assert property (
    wr_to(ptl_pkg::IDX_LEVEL_TENTH) |=> second_preset_level_ten_o == $past(dat_i[7:0]))
    else $error("level ten wrong");
  a_level_eleven_byte: assert property (
    wr_to(ptl_pkg::IDX_LEVEL_ELEVENTH) |=> second_preset_level_eleven_o == $past(dat_i[7:0]))
    else $error("level eleven wrong");
  a_level_twelve_byte: assert property (
    wr_to(ptl_pkg::IDX_LEVEL_TWELFTH) |=> second_preset_level_twelve_o == $past(dat_i[7:0]))
    else $error("level twelve wrong");
  a_offset_read_back: assert property (
    req && !ack_o && !we_i && bus_idx == ptl_pkg::IDX_LEVEL_OFFSET
    |=> dat_o == {28'h000_0000, second_preset_level_offset_o})
    else $error("offset readback wrong");
  a_reserved_reads_zero: assert property (
    wr_to(ptl_pkg::IDX_LEVEL_OFFSET) |=> map_q[8][7:4] == 4'h0)
    else $error("reserved offset bits took a write");
  a_checksum_not_written: assert property (
    checksum_seen && !crc_done |=> $stable(checksum))
    else $error("checksum changed without engine");
  a_checksum_read_back: assert property (
    req && !ack_o && !we_i && bus_idx == ptl_pkg::IDX_CHECKSUM && checksum_seen
    |=> dat_o == {24'h00_0000, $past(checksum)})
    else $error("checksum readback wrong");
  a_unmapped_reads_zero: assert property (
    req && !ack_o && !we_i && bus_idx < ptl_pkg::IDX_LEVEL_FOUR_TOP |=> dat_o == 32'h0000_0000)
    else $error("unmapped index read nonzero");
  // a later write restarts the walk, so only an undisturbed walk has a fixed end
  a_checksum_refresh: assert property (
    map_write ##1 (!map_write) [*8] ##1 !map_write |=> crc_done)
    else $error("checksum not refreshed after map write");

  c_map_write: cover property (map_write);
  c_map_read: cover property (req && !we_i && ack_o && bus_idx == ptl_pkg::IDX_LEVEL_NINTH);
  c_crc_restart: cover property (checksum_busy_o && map_write);
  c_crc_done: cover property (crc_done);

endmodule

// *** ptl_level_bank_bench.sv ***
`timescale 1ns/1ps
module ptl_level_bank_bench;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, checksum_busy_o;
  logic [8:0] adr_i;
  logic [3:0] sel_i, offs;
  logic [31:0] dat_i, dat_o, q;
  logic [4:0] l4, l5, l6, l7, l8;
  logic [7:0] l9, l10, l11, l12, crc;
  logic [7:0] mem [0:8];
  int mismatches, checks_done;

  ptl_level_bank u_ptl_level_bank (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .second_preset_level_four_o(l4), .second_preset_level_five_o(l5),
    .second_preset_level_six_o(l6), .second_preset_level_seven_o(l7),
    .second_preset_level_eight_o(l8), .second_preset_level_nine_o(l9),
    .second_preset_level_ten_o(l10), .second_preset_level_eleven_o(l11),
    .second_preset_level_twelve_o(l12), .second_preset_level_offset_o(offs),
    .threshold_map_checksum_o(crc), .checksum_busy_o(checksum_busy_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one classic cycle; the master never assumes the answer latency
  task automatic wb(input logic w, input logic [6:0] idx, input logic [7:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= s;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      give_verdict();
    end
  endtask

  function automatic logic [7:0] crc_of();
    logic [7:0] c;
    c = ptl_pkg::CRC_INIT;
    for (int i = 0; i < 9; i++) begin
      c = c ^ (mem[i] & ptl_pkg::MAP_MASK[i]);
      for (int b = 0; b < 8; b++) c = c[7] ? ({c[6:0], 1'b0} ^ ptl_pkg::CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // a walk must start and end inside a bounded window
  task automatic wait_crc;
    int n;
    n = 0;
    repeat (2) @(posedge clk_i);
    chk("busy", checksum_busy_o, 1'b1);
    while (checksum_busy_o !== 1'b0 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 40) begin
      mismatches++;
      give_verdict();
    end
    // the register takes the result one edge after busy falls
    @(posedge clk_i);
    chk("crc port", crc, crc_of());
    wb(1'b0, 7'h7f, 8'h00, 4'hf);
    chk("crc read", q, {24'h0, crc_of()});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 9'h000;
    sel_i = 4'h0;
    dat_i = 32'h0;
    mismatches = 0;
    checks_done = 0;
    mem = '{8'hff, 8'h9c, 8'h6b, 8'hd2, 8'h35, 8'ha7, 8'h48, 8'he1, 8'hfe};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 9; i++) wb(1'b1, 7'h76 + 7'(i), mem[i], 4'hf);
    wait_crc();
    chk("level4", l4, {mem[0][0], mem[1][7:4]});
    chk("level5", l5, {mem[1][3:0], mem[2][7]});
    chk("level6", l6, mem[2][6:2]);
    chk("level7", l7, {mem[2][1:0], mem[3][7:5]});
    chk("level8", l8, mem[3][4:0]);
    chk("level9", l9, mem[4]);
    chk("level10", l10, mem[5]);
    chk("level11", l11, mem[6]);
    chk("level12", l12, mem[7]);
    chk("offset", offs, mem[8][3:0]);
    for (int i = 0; i < 9; i++) begin
      wb(1'b0, 7'h76 + 7'(i), 8'h00, 4'hf);
      chk("readback", q, {24'h0, mem[i] & ptl_pkg::MAP_MASK[i]});
    end
    // offset extremes +7 and -8, with the reserved nibble nonzero
    mem[8] = 8'hf7;
    wb(1'b1, 7'h7e, mem[8], 4'hf);
    wait_crc();
    chk("offset max", offs, 4'h7);
    mem[8] = 8'ha8;
    wb(1'b1, 7'h7e, mem[8], 4'hf);
    wait_crc();
    chk("offset min", offs, 4'h8);
    wb(1'b0, 7'h7e, 8'h00, 4'hf);
    chk("offset reserved", q, 32'h08);
    // checksum is read-only for software
    wb(1'b1, 7'h7f, ~crc_of(), 4'hf);
    wb(1'b0, 7'h7f, 8'h00, 4'hf);
    chk("crc readonly", q, {24'h0, crc_of()});
    // low lane disabled: the write must not land
    wb(1'b1, 7'h7a, 8'h00, 4'he);
    wb(1'b0, 7'h7a, 8'h00, 4'hf);
    chk("sel ignored", q, {24'h0, mem[4]});
    // unmapped index reads zero
    wb(1'b1, 7'h05, 8'hff, 4'hf);
    wb(1'b0, 7'h05, 8'h00, 4'hf);
    chk("unmapped", q, 32'h0);
    // a second write during the walk restarts it
    mem[6] = 8'h11;
    mem[7] = 8'h22;
    wb(1'b1, 7'h7c, mem[6], 4'hf);
    wb(1'b1, 7'h7d, mem[7], 4'hf);
    wait_crc();
    chk("level11 new", l11, 8'h11);
    chk("level12 new", l12, 8'h22);
    give_verdict();
  end
endmodule
